// ### design/core_alu_pkg.sv
package core_alu_pkg;

  // datapath and bus widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FILE_AW = 7;
  localparam int unsigned PTR_W   = 16;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned BUS_W   = 32;

  // register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFS_INSTR  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_ACC    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PTR0   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_PTR1   = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FADDR  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FDATA  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CYCLES = 6'h1C;

  // reset values
  localparam logic [DATA_W-1:0]  ACC_RST    = 8'h00;
  localparam logic [2:0]         STATUS_RST = 3'h0;
  localparam logic [PTR_W-1:0]   PTR_RST    = 16'h0000;
  localparam logic [INSTR_W-1:0] INSTR_RST  = 14'h0000;

  // opcode prefixes of the 14-bit instruction word
  localparam logic [6:0] OPC_PTR_ADD   = 7'h62;
  localparam logic [5:0] OPC_LIT_ADD   = 6'h3E;
  localparam logic [5:0] OPC_LIT_MASK  = 6'h39;
  localparam logic [5:0] OPC_FILE_MASK = 6'h05;
  localparam logic [5:0] OPC_FILE_ADD  = 6'h07;
  localparam logic [5:0] OPC_FILE_ADC  = 6'h3D;
  localparam logic [5:0] OPC_SHIFT     = 6'h37;
  localparam logic [3:0] OPC_BIT_ZERO  = 4'h4;

  // indirect alias file addresses and pointer stretch bit
  localparam logic [FILE_AW-1:0] ALIAS0_ADDR = 7'h00;
  localparam logic [FILE_AW-1:0] ALIAS1_ADDR = 7'h01;
  localparam int unsigned        PTR_MSB     = 15;

  typedef struct packed {
    logic z;   // result_null_bit
    logic dc;  // nibble_overflow_bit
    logic c;   // arith_overflow_bit
  } status_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [BUS_W-1:0]  writedata;
  } av_req_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_PTR_ADD, OP_LIT_ADD, OP_LIT_MASK, OP_FILE_MASK,
    OP_FILE_ADD, OP_FILE_ADC, OP_SHIFT, OP_BIT_ZERO
  } op_t;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_STALL, S_EXEC} state_t;

endpackage : core_alu_pkg

// ### design/file_ram.sv
module file_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW    = 7
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // storage has no reset, like the data memory it models
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // registered read, old data on a same-address write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule : file_ram

// ### design/core_arith_logic_ops.sv
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
module core_arith_logic_ops
  import core_alu_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 128
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire av_req_t          avs_i,
  output logic      [BUS_W-1:0] avs_readdata_o,
  output logic                  avs_waitrequest_o
);

  state_t             state_q, state_d;
  logic [INSTR_W-1:0] instr_q;
  logic [DATA_W-1:0]  acc_q;
  status_t            status_q;
  logic [PTR_W-1:0]   ptr0_q, ptr1_q;
  logic [FILE_AW-1:0] faddr_q;
  logic [15:0]        cycles_q;
  logic               wait_q;
  logic [BUS_W-1:0]   rdata_q;

  // instruction fields
  wire [DATA_W-1:0]  lit  = instr_q[7:0];
  wire [FILE_AW-1:0] fsel = instr_q[6:0];
  wire               dest = instr_q[7];
  wire [2:0]         bsel = instr_q[9:7];
  wire               psel = instr_q[6];
  wire [5:0]         kval = instr_q[5:0];

  // opcode decode, pointer add checked first
  op_t op;
  assign op = (instr_q[13:7] == OPC_PTR_ADD)   ? OP_PTR_ADD   :
              (instr_q[13:8] == OPC_LIT_ADD)   ? OP_LIT_ADD   :
              (instr_q[13:8] == OPC_LIT_MASK)  ? OP_LIT_MASK  :
              (instr_q[13:8] == OPC_FILE_MASK) ? OP_FILE_MASK :
              (instr_q[13:8] == OPC_FILE_ADD)  ? OP_FILE_ADD  :
              (instr_q[13:8] == OPC_FILE_ADC)  ? OP_FILE_ADC  :
              (instr_q[13:8] == OPC_SHIFT)     ? OP_SHIFT     :
              (instr_q[13:10] == OPC_BIT_ZERO) ? OP_BIT_ZERO  : OP_NONE;

  wire ex        = (state_q == S_EXEC);
  wire idle      = (state_q == S_IDLE);
  wire is_add    = (op == OP_LIT_ADD) | (op == OP_FILE_ADD) | (op == OP_FILE_ADC);
  wire is_mask   = (op == OP_LIT_MASK) | (op == OP_FILE_MASK);
  wire dest_op   = (op == OP_FILE_MASK) | (op == OP_FILE_ADD) | (op == OP_FILE_ADC) |
                   (op == OP_SHIFT);
  wire uses_file = dest_op | (op == OP_BIT_ZERO);

  // indirect alias resolves through the pointer low bits
  wire               alias0    = uses_file & (fsel == ALIAS0_ADDR);
  wire               alias_hit = alias0 | (uses_file & (fsel == ALIAS1_ADDR));
  wire [PTR_W-1:0]   alias_ptr = alias0 ? ptr0_q : ptr1_q;
  wire [FILE_AW-1:0] eff_addr  = alias_hit ? alias_ptr[FILE_AW-1:0] : fsel;
  wire               stretch   = alias_hit & alias_ptr[PTR_MSB];

  // operand and adder, nibble carry taken separately
  logic [DATA_W-1:0] fdata;
  wire [DATA_W-1:0] opnd  = (op == OP_LIT_ADD || op == OP_LIT_MASK) ? lit : fdata;
  wire              cin   = (op == OP_FILE_ADC) & status_q.c;
  wire [8:0]        sum9  = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
  wire [4:0]        nib5  = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire [DATA_W-1:0] and8  = acc_q & opnd;
  wire [DATA_W-1:0] shr8  = {fdata[7], fdata[7:1]};
  wire [DATA_W-1:0] bclr8 = fdata & ~(8'h01 << bsel);

  // result select and routing by destination bit
  wire [DATA_W-1:0] result = is_add           ? sum9[7:0] :
                             is_mask          ? and8      :
                             (op == OP_SHIFT) ? shr8      : bclr8;
  wire to_acc  = (op == OP_LIT_ADD) | (op == OP_LIT_MASK) | (dest_op & ~dest);
  wire to_file = (op == OP_BIT_ZERO) | (dest_op & dest);
  wire upd_z   = is_add | is_mask | (op == OP_SHIFT);
  wire upd_c   = is_add | (op == OP_SHIFT);
  wire upd_dc  = is_add;

  // flags: carry out of bit 7 (operand bit 0 on a shift) and bit 3, zero result
  status_t flags_new;
  assign flags_new.z  = upd_z  ? (result == 8'h00) : status_q.z;
  assign flags_new.dc = upd_dc ? nib5[4] : status_q.dc;
  assign flags_new.c  = !upd_c ? status_q.c :
                        (op == OP_SHIFT) ? fdata[0] : sum9[8];

  // pointer add wraps naturally at 16 bits
  wire [PTR_W-1:0] k_sext  = {{10{kval[5]}}, kval};
  wire [PTR_W-1:0] ptr_sum = (psel ? ptr1_q : ptr0_q) + k_sext;
  wire             ptr_ex  = ex & (op == OP_PTR_ADD);

  // bus decode; accepted only when idle, so no clash with execution
  wire accept   = (avs_i.read | avs_i.write) & wait_q & idle;
  wire wr       = accept & avs_i.write;
  wire [ADDR_W-1:0] a = {avs_i.address[ADDR_W-1:2], 2'b00};
  wire wr_instr = wr & (a == OFS_INSTR);
  wire wr_fdata = wr & (a == OFS_FDATA);

  logic [BUS_W-1:0] rd_mux;
  assign rd_mux = (a == OFS_INSTR)  ? {17'h0, ~idle, 14'(instr_q)} :
                  (a == OFS_ACC)    ? {24'h0, acc_q} :
                  (a == OFS_STATUS) ? {29'h0, status_q} :
                  (a == OFS_PTR0)   ? {16'h0, ptr0_q} :
                  (a == OFS_PTR1)   ? {16'h0, ptr1_q} :
                  (a == OFS_FADDR)  ? {25'h0, faddr_q} :
                  (a == OFS_FDATA)  ? {24'h0, fdata} :
                  (a == OFS_CYCLES) ? {16'h0, cycles_q} : 32'h0000_0000;

  // file memory: bus window when idle, operand address while executing
  wire [FILE_AW-1:0] mem_addr = idle ? faddr_q : eff_addr;
  wire               mem_we   = wr_fdata | (ex & to_file);
  wire [DATA_W-1:0]  mem_wdat = idle ? avs_i.writedata[7:0] : result;

  file_ram #(
    .WIDTH (DATA_W),
    .DEPTH (FILE_DEPTH),
    .AW    (FILE_AW)
  ) u_file_ram (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdat),
    .rdata_o (fdata)
  );

  // sequencer: operand fetch, optional stretch, one execute cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE:  state_d = wr_instr ? S_FETCH : S_IDLE;
      S_FETCH: state_d = stretch ? S_STALL : S_EXEC;
      S_STALL: state_d = S_EXEC;
      S_EXEC:  state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) state_q <= S_IDLE;
    else         state_q <= state_d;
  end

  // waitrequest drops for exactly one cycle per accepted access
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= ~accept;
      rdata_q <= (accept & avs_i.read) ? rd_mux : rdata_q;
    end
  end

  // instruction, file address and busy-cycle counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      instr_q  <= INSTR_RST;
      faddr_q  <= '0;
      cycles_q <= '0;
    end else begin
      if (wr_instr) instr_q <= avs_i.writedata[INSTR_W-1:0];
      if (wr & (a == OFS_FADDR)) faddr_q <= avs_i.writedata[FILE_AW-1:0];
      if (!idle) cycles_q <= cycles_q + 16'h0001;
    end
  end

  // accumulator and flags: bus writes when idle, results in execute
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_q    <= ACC_RST;
      status_q <= STATUS_RST;
    end else begin
      if (wr & (a == OFS_ACC))         acc_q <= avs_i.writedata[DATA_W-1:0];
      else if (ex & to_acc)            acc_q <= result;
      if (wr & (a == OFS_STATUS))      status_q <= avs_i.writedata[2:0];
      else if (ex & (op != OP_PTR_ADD)) status_q <= flags_new;
    end
  end

  // indirect pointers; pointer add leaves flags alone
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ptr0_q <= PTR_RST;
      ptr1_q <= PTR_RST;
    end else begin
      if (wr & (a == OFS_PTR0))  ptr0_q <= avs_i.writedata[PTR_W-1:0];
      else if (ptr_ex & !psel)   ptr0_q <= ptr_sum;
      if (wr & (a == OFS_PTR1))  ptr1_q <= avs_i.writedata[PTR_W-1:0];
      else if (ptr_ex & psel)    ptr1_q <= ptr_sum;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // sign extension rebuilt from the literal field, not taken from the datapath
  a_ptr_offset: assert property (
    ptr_ex & !psel |=> ptr0_q == 16'($past(ptr0_q) + {{10{$past(kval[5])}}, $past(kval)}))
    else $error("pointer add wrong");
  a_ptr_flags_kept: assert property (
    ptr_ex |=> $stable(status_q))
    else $error("pointer add changed flags");
  a_ptr_wrap_top: assert property (
    ptr_ex & psel |=> ptr1_q == 16'($past(ptr1_q) + {{10{$past(kval[5])}}, $past(kval)}))
    else $error("pointer did not wrap");
  a_lit_add_sum: assert property (
    ex & op == OP_LIT_ADD |=>
    acc_q == 8'($past(acc_q) + $past(lit)) && status_q.z == (acc_q == 8'h00))
    else $error("literal add wrong");
  a_lit_mask_only: assert property (
    ex & op == OP_LIT_MASK |=>
    acc_q == ($past(acc_q) & $past(lit)) && status_q.c == $past(status_q.c))
    else $error("literal mask wrong");
  a_mask_to_file: assert property (
    ex & op == OP_FILE_MASK & dest |=> $stable(acc_q))
    else $error("file mask hit accumulator");
  a_file_add_acc: assert property (
    ex & op == OP_FILE_ADD & !dest |=> acc_q == 8'($past(acc_q) + $past(fdata)))
    else $error("file add wrong");
  a_adc_carry_in: assert property (
    ex & op == OP_FILE_ADC & !dest |=>
    acc_q == 8'($past(acc_q) + $past(fdata) + {7'h00, $past(status_q.c)}))
    else $error("add with carry wrong");
  a_shift_carry: assert property (
    ex & op == OP_SHIFT |=> status_q.c == $past(fdata[0]))
    else $error("shift carry wrong");
  a_bit_zero_flags: assert property (
    ex & op == OP_BIT_ZERO |=> $stable(status_q))
    else $error("bit clear changed flags");
  a_exec_one_cycle: assert property (ex |=> idle) else $error("execute not single");
  a_stretch_path: assert property (
    state_q == S_FETCH & stretch |=> state_q == S_STALL ##1 ex)
    else $error("stretch cycle missing");
  a_nibble_carry: assert property (
    ex & op == OP_FILE_ADD |=> status_q.dc == $past(nib5[4]))
    else $error("nibble carry wrong");
  a_file_address: assert property (
    state_q == S_FETCH & uses_file & !alias_hit |-> mem_addr == fsel)
    else $error("file address wrong");

  c_stretch: cover property (state_q == S_STALL);
  c_ptr_wrap: cover property (ptr_ex & ptr0_q == 16'h0000 & kval[5] & !psel);
  c_adc_carry: cover property (ex & op == OP_FILE_ADC & status_q.c & sum9[8]);
  c_file_dest: cover property (ex & to_file);

endmodule : core_arith_logic_ops

// ### dv/tb_top.sv
module tb_top
  import core_alu_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  // one table row: file address, inputs, instruction word, expected results
  typedef struct packed {
    logic [6:0]  fa;
    logic [7:0]  acc;
    logic [7:0]  st;
    logic [7:0]  fv;
    logic [13:0] ins;
    logic [7:0]  eacc;
    logic [7:0]  est;
    logic [7:0]  ef;
  } vec_t;

  typedef struct packed {
    logic        n;
    logic [5:0]  k;
    logic [15:0] p;
    logic [15:0] e;
  } pv_t;

  logic             clk_i;
  logic             reset_i;
  av_req_t          avs;
  logic [BUS_W-1:0] avs_readdata_o;
  logic             avs_waitrequest_o;
  int               fails;
  int               n_compared;

  // status in: [0] carry, [1] nibble carry, [2] zero
  vec_t vecs [18] = '{
    '{7'h25, 8'h88, 8'h0, 8'h11, 14'h3E78, 8'h00, 8'h7, 8'h11},
    '{7'h25, 8'h0E, 8'h4, 8'h11, 14'h3E01, 8'h0F, 8'h0, 8'h11},
    '{7'h25, 8'hF0, 8'h3, 8'h11, 14'h390F, 8'h00, 8'h7, 8'h11},
    '{7'h25, 8'hFF, 8'h7, 8'h11, 14'h393C, 8'h3C, 8'h3, 8'h11},
    '{7'h25, 8'h0F, 8'h3, 8'h3C, 14'h0525, 8'h0C, 8'h3, 8'h3C},
    '{7'h25, 8'h0F, 8'h0, 8'hF0, 14'h05A5, 8'h0F, 8'h4, 8'h00},
    '{7'h25, 8'h0F, 8'h0, 8'h01, 14'h0725, 8'h10, 8'h2, 8'h01},
    '{7'h25, 8'hFF, 8'h0, 8'h01, 14'h07A5, 8'hFF, 8'h7, 8'h00},
    '{7'h25, 8'h0F, 8'h1, 8'h00, 14'h3D25, 8'h10, 8'h2, 8'h00},
    '{7'h25, 8'h7F, 8'h1, 8'h80, 14'h3DA5, 8'h7F, 8'h7, 8'h00},
    '{7'h25, 8'h01, 8'h0, 8'h01, 14'h3D25, 8'h02, 8'h0, 8'h01},
    '{7'h25, 8'h00, 8'h0, 8'h81, 14'h3725, 8'hC0, 8'h1, 8'h81},
    '{7'h25, 8'h55, 8'h2, 8'h01, 14'h37A5, 8'h55, 8'h7, 8'h00},
    '{7'h25, 8'h00, 8'h1, 8'h40, 14'h3725, 8'h20, 8'h0, 8'h40},
    '{7'h25, 8'h33, 8'h5, 8'hFF, 14'h13A5, 8'h33, 8'h5, 8'h7F},
    '{7'h25, 8'h33, 8'h2, 8'h01, 14'h1025, 8'h33, 8'h2, 8'h00},
    '{7'h25, 8'h33, 8'h0, 8'hFF, 14'h11A5, 8'h33, 8'h0, 8'hF7},
    '{7'h7F, 8'h01, 8'h0, 8'h7F, 14'h07FF, 8'h01, 8'h2, 8'h80}
  };

  // wrap both ways and both pointer selects
  pv_t pvs [4] = '{
    '{1'b0, 6'h1F, 16'hFFF0, 16'h000F},
    '{1'b1, 6'h20, 16'h0010, 16'hFFF0},
    '{1'b0, 6'h3F, 16'h1234, 16'h1233},
    '{1'b1, 6'h1F, 16'h0000, 16'h001F}
  };

  core_arith_logic_ops core_arith_logic_ops_i (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .avs_i             (avs),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o)
  );

  // free running clock, 100 ns period
  always #50 clk_i = ~clk_i;

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                     output logic [BUS_W-1:0] q);
    int n;
    avs.read      <= ~wr;
    avs.write     <= wr;
    avs.address   <= a;
    avs.writedata <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 200);
    q = avs_readdata_o;
    if (n >= 200) fails++;
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
    // idle edge so the next request is not raised in the same step
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
    logic [BUS_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] e);
    logic [BUS_W-1:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rd_chk

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    complete_run();
  end

  initial begin
    logic [BUS_W-1:0] c0;
    logic [BUS_W-1:0] c1;
    vec_t             v;
    pv_t              pv;
    clk_i   = 1'b0;
    reset_i = 1'b1;
    avs     = '0;
    fails      = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    // reset values, read-back masking and unmapped space
    // file data left out: the file memory holds no reset value
    for (int i = 0; i < 8; i++) begin
      if (i != 6) rd_chk("reset", 6'(4 * i), 32'h0);
    end
    wr(6'h20, 32'hFFFF_FFFF);
    rd_chk("unmapped", 6'h20, 32'h0);
    rd_chk("unmapped", 6'h3C, 32'h0);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk("status mask", OFS_STATUS, 32'h7);
    // accumulator and file operations from the table
    foreach (vecs[i]) begin
      v = vecs[i];
      wr(OFS_FADDR, {25'h0, v.fa});
      wr(OFS_FDATA, {24'h0, v.fv});
      wr(OFS_ACC, {24'h0, v.acc});
      wr(OFS_STATUS, {24'h0, v.st});
      wr(OFS_INSTR, {18'h0, v.ins});
      rd_chk("acc", OFS_ACC, {24'h0, v.eacc});
      rd_chk("status", OFS_STATUS, {24'h0, v.est});
      rd_chk("file", OFS_FDATA, {24'h0, v.ef});
      rd_chk("instr", OFS_INSTR, {18'h0, v.ins});
    end
    // pointer offset add, other pointer and flags untouched
    foreach (pvs[i]) begin
      pv = pvs[i];
      wr(pv.n ? OFS_PTR0 : OFS_PTR1, 32'h0000_A5A5);
      wr(pv.n ? OFS_PTR1 : OFS_PTR0, {16'h0, pv.p});
      wr(OFS_STATUS, 32'h5);
      wr(OFS_INSTR, {18'h0, 7'h62, pv.n, pv.k});
      rd_chk("ptr", pv.n ? OFS_PTR1 : OFS_PTR0, {16'h0, pv.e});
      rd_chk("other ptr", pv.n ? OFS_PTR0 : OFS_PTR1, 32'h0000_A5A5);
      rd_chk("ptr flags", OFS_STATUS, 32'h5);
    end
    // alias access; pointer msb adds one busy cycle
    for (int s = 0; s < 2; s++) begin
      wr(OFS_PTR1, s ? 32'h0000_8030 : 32'h0000_0030);
      wr(OFS_FADDR, 32'h30);
      wr(OFS_FDATA, 32'h0A);
      wr(OFS_ACC, 32'h05);
      wr(OFS_STATUS, 32'h0);
      bus(1'b0, OFS_CYCLES, 32'h0, c0);
      wr(OFS_INSTR, 32'h0701);
      rd_chk("alias acc", OFS_ACC, 32'h0F);
      bus(1'b0, OFS_CYCLES, 32'h0, c1);
      check("busy cycles", {16'h0, c1[15:0] - c0[15:0]}, s ? 32'h3 : 32'h2);
    end
    complete_run();
  end

endmodule : tb_top
